// ==== logic/ivs_top.sv ====
// Interrupt option register, vector selection and power mode control
//
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ns
module ivs_top
   import ivs_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   input wire logic nmi_line,
   input wire logic port_a_line,
   input wire logic port_bc_line,
   input wire logic timer_zero_flag,
   input wire logic timer_irq_en,
   input wire logic converter_flag,
   input wire logic converter_irq_en,
   input wire logic core_ack,
   input wire logic exec_wait,
   input wire logic exec_stop,
   output logic irq_req,
   output logic [11:0] irq_vector,
   output logic [1:0] power_mode,
   output logic low_freq_aux_oscillator,
   output logic core_wake,
   output logic irq
);
   // ***********************************************
   // Registers
   // ***********************************************
   logic [7:0] interrupt_option_reg;
   logic aux_sel;
   logic [IVS_NSRC-1:0] irq_status;
   logic [IVS_NSRC-1:0] irq_enable;
   logic nmi_q;
   logic nmi_latch;
   ivs_mode_e mode;
   ivs_mode_e next_mode;
   logic [IVS_NSRC-1:0] grant;
   logic [11:0] vec;
   logic any;
   logic req_a;
   logic req_bc;
   // ***********************************************
   // Decode
   // ***********************************************
   wire wr_opt = wr & (addr == IVS_OPTION_ADDR);
   wire wr_clk = wr & (addr == IVS_CLOCK_ADDR);
   wire wr_en = wr & (addr == IVS_IRQ_ENABLE_ADDR);
   wire wr_clr = wr & (addr == IVS_IRQ_CLEAR_ADDR);
   wire gen = interrupt_option_reg[IVS_GEN_BIT];
   wire level_sel = interrupt_option_reg[IVS_LEVEL_BIT];
   wire pol_sel = interrupt_option_reg[IVS_POLARITY_BIT];
   wire ack_a = core_ack & grant[1];
   wire ack_bc = core_ack & grant[2];
   // Vector 1 and 2 request latches
   ivs_edge_latch u_vec1 (
      .clk(clk),
      .rst_b(rst_b),
      .line(port_a_line),
      .level_mode(level_sel),
      .rising(1'b0),
      .ack(ack_a),
      .req(req_a)
   );
   ivs_edge_latch u_vec2 (
      .clk(clk),
      .rst_b(rst_b),
      .line(port_bc_line),
      .level_mode(1'b0),
      .rising(pol_sel),
      .ack(ack_bc),
      .req(req_bc)
   );
   // Maskable sources gated by the global enable; peripherals by own enable
   wire tmr_req = timer_zero_flag & timer_irq_en;
   wire adc_req = converter_flag & converter_irq_en;
   wire [IVS_NSRC-1:0] raw = {adc_req, tmr_req, req_bc, req_a, nmi_latch};
   wire [IVS_NSRC-1:0] gated = raw & {{(IVS_NSRC-1){gen}}, 1'b1};
   ivs_prio_enc u_prio (
      .pend(gated),
      .any(any),
      .vector(vec),
      .grant(grant)
   );
   // Wake: wait by any request once enabled; stop only by allowed sources
   wire wake_wait = gen & |gated;
   wire wake_stop = gen & |(gated & IVS_STOP_WAKE);
   wire nmi_fall = nmi_q & ~nmi_line;
   // Power mode sequencing
   always_comb begin
      next_mode = mode;
      case (mode)
         IVS_RUN: begin
            if (exec_stop && !any) begin
               next_mode = IVS_STOP;
            end else if (exec_wait && !any) begin
               next_mode = IVS_WAIT;
            end
         end
         IVS_WAIT: if (wake_wait) next_mode = IVS_RUN;
         IVS_STOP: if (wake_stop) next_mode = IVS_RUN;
         default: next_mode = IVS_RUN;
      endcase
   end
   // Option register, aux oscillator select and mode state
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         interrupt_option_reg <= IVS_OPTION_RESET;
         aux_sel <= 1'b0;
         mode <= IVS_RUN;
      end else begin
         if (wr_opt) interrupt_option_reg <= wdata;
         if (wr_clk) aux_sel <= wdata[IVS_AUX_BIT];
         mode <= next_mode;
      end
   end
   // Non-maskable falling edge latch, cleared on its own service
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         nmi_q <= 1'b1;
         nmi_latch <= 1'b0;
      end else begin
         nmi_q <= nmi_line;
         nmi_latch <= nmi_fall | (nmi_latch & ~(core_ack & grant[IVS_SRC_NMI]));
      end
   end
   // Sticky event status; set wins over clear
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         irq_status <= '0;
         irq_enable <= '0;
      end else begin
         irq_status <= raw | (irq_status & ~(wr_clr ? wdata[IVS_NSRC-1:0] : '0));
         if (wr_en) irq_enable <= wdata[IVS_NSRC-1:0];
      end
   end
   // Read mux; the option register is write-only and reads zero
   wire [7:0] rd_mux = (addr == IVS_IRQ_STATUS_ADDR) ? 8'(irq_status) :
                       (addr == IVS_IRQ_ENABLE_ADDR) ? 8'(irq_enable) :
                       (addr == IVS_CLOCK_ADDR) ? 8'(aux_sel) :
                       (addr == IVS_MODE_ADDR) ? 8'(mode) : 8'h00;
   // Registered outputs
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         rdata <= 8'h00;
         irq_req <= 1'b0;
         irq_vector <= IVS_VEC_RESET;
         power_mode <= 2'(IVS_RUN);
         low_freq_aux_oscillator <= 1'b0;
         core_wake <= 1'b0;
         irq <= 1'b0;
      end else begin
         rdata <= rd ? rd_mux : 8'h00;
         irq_req <= any & ~core_ack;
         irq_vector <= vec;
         power_mode <= 2'(next_mode);
         low_freq_aux_oscillator <= aux_sel & (next_mode != IVS_STOP);
         core_wake <= (mode != IVS_RUN) && (next_mode == IVS_RUN);
         irq <= |(irq_status & irq_enable);
      end
   end
   // ***********************************************
   // Checks
   // ***********************************************
   opt_reset_a: assert property (@(posedge clk) !rst_b |=> interrupt_option_reg == 8'h00)
      else $error("option register not cleared");
   opt_write_a: assert property (@(posedge clk) disable iff (!rst_b)
      wr_opt |=> interrupt_option_reg == $past(wdata))
      else $error("option write lost");
   gen_mask_a: assert property (@(posedge clk) disable iff (!rst_b)
      !gen |-> gated[IVS_SRC_ADC:1] == '0)
      else $error("maskable source passed with enable off");
   nmi_pass_a: assert property (@(posedge clk) disable iff (!rst_b)
      nmi_latch |-> any && gated[IVS_SRC_NMI])
      else $error("nmi not requested");
   stop_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
      (mode == IVS_STOP && !gen) |=> mode == IVS_STOP)
      else $error("stop left with enable off");
   adc_nowake_a: assert property (@(posedge clk) disable iff (!rst_b)
      (mode == IVS_STOP && gated == 5'h10) |=> mode == IVS_STOP)
      else $error("conversion woke from stop");
   timer_wake_a: assert property (@(posedge clk) disable iff (!rst_b)
      (mode == IVS_STOP && gated[3]) |=> mode == IVS_RUN)
      else $error("timer did not wake stop");
   prio_vec_a: assert property (@(posedge clk) disable iff (!rst_b)
      (gated[1] && !gated[0]) |=> irq_vector == IVS_VEC_PORT_A)
      else $error("vector 1 not preferred");
   level_req_a: assert property (@(posedge clk) disable iff (!rst_b)
      level_sel |-> req_a == !port_a_line)
      else $error("level mode request wrong");
   run_reset_a: assert property (@(posedge clk) !rst_b |=> mode == IVS_RUN)
      else $error("reset did not enter run");
   // Outputs leave reset in run mode with the reset vector offered
   pwr_reset_a: assert property (@(posedge clk)
      !rst_b |=> power_mode == 2'(IVS_RUN) && irq_vector == IVS_VEC_RESET)
      else $error("outputs not at reset values");
   // Edge detection on both external vectors; skip the cycle after reset
   vec1_fall_a: assert property (@(posedge clk) disable iff (!rst_b)
      (!level_sel && $past(rst_b) && $fell(port_a_line)) |=> req_a)
      else $error("vector 1 falling edge missed");
   vec2_rise_a: assert property (@(posedge clk) disable iff (!rst_b)
      (pol_sel && $past(rst_b) && $rose(port_bc_line)) |=> req_bc)
      else $error("vector 2 rising edge missed");
   vec2_fall_a: assert property (@(posedge clk) disable iff (!rst_b)
      (!pol_sel && $past(rst_b) && $fell(port_bc_line)) |=> req_bc)
      else $error("vector 2 falling edge missed");
   // The non-maskable latch catches every falling edge, enable or not
   nmi_catch_a: assert property (@(posedge clk) disable iff (!rst_b)
      nmi_fall |=> nmi_latch)
      else $error("nmi edge not latched");
   // Peripheral flags need their own enable
   periph_gate_a: assert property (@(posedge clk) disable iff (!rst_b)
      (!timer_irq_en && !converter_irq_en) |-> gated[IVS_SRC_ADC:3] == '0)
      else $error("peripheral passed with its enable off");
   // Wake paths out of wait and stop
   wait_wake_a: assert property (@(posedge clk) disable iff (!rst_b)
      (mode == IVS_WAIT && gen && |gated) |=> mode == IVS_RUN)
      else $error("enabled request did not end wait");
   port_wake_a: assert property (@(posedge clk) disable iff (!rst_b)
      (mode == IVS_STOP && (gated[1] || gated[2])) |=> mode == IVS_RUN)
      else $error("port request did not end stop");
   nmi_wake_a: assert property (@(posedge clk) disable iff (!rst_b)
      (mode == IVS_STOP && gen && gated[IVS_SRC_NMI]) |=> mode == IVS_RUN)
      else $error("nmi did not end stop");
   // Stop entry, and no entry while a request waits
   stop_entry_a: assert property (@(posedge clk) disable iff (!rst_b)
      (mode == IVS_RUN && exec_stop && !any) |=> mode == IVS_STOP)
      else $error("stop instruction not obeyed");
   busy_entry_a: assert property (@(posedge clk) disable iff (!rst_b)
      (mode == IVS_RUN && any) |=> mode == IVS_RUN)
      else $error("low power entered with request pending");
   // Auxiliary oscillator select reaches its output outside stop
   aux_out_a: assert property (@(posedge clk) disable iff (!rst_b)
      (aux_sel && next_mode != IVS_STOP) |=> low_freq_aux_oscillator)
      else $error("aux oscillator not selected");
   // The write-only option register never shows on the read port
   opt_read_a: assert property (@(posedge clk) disable iff (!rst_b)
      (rd && addr == IVS_OPTION_ADDR) |=> rdata == 8'h00)
      else $error("option register readable");
endmodule : ivs_top

// ==== logic/ivs_pkg.sv ====
// Package of constants and types for the interrupt vector select block
//
// Overview of operation
// - Level bit set: vector 1 low-level sensitive
// - Level bit clear: vector 1 falling edge
// - Polarity bit: vector 2 falling or rising
// - Global enable gates every maskable source; the irq output is not gated by it
// - Non-maskable serviced, wakes only when enabled
// - Option register write-only, cleared on reset
// - Port A vector, wakes from stop
// - Ports B and C vector, wakes stop
// - Timer underflow vector, wakes from stop
// - End of conversion vector, no stop wake
// - Fixed priority, non-maskable highest, then vector 1
// - Peripheral flag needs both enables, persists
// - Reset enters run mode, main clock
// - Wait and stop entered by instructions
// - Register bit selects auxiliary oscillator
package ivs_pkg;
   // ***********************************************
   // Register map
   // ***********************************************
   localparam logic [7:0] IVS_OPTION_ADDR = 8'hc8;
   localparam logic [7:0] IVS_CLOCK_ADDR = 8'hc9;
   localparam logic [7:0] IVS_IRQ_STATUS_ADDR = 8'hca;
   localparam logic [7:0] IVS_IRQ_ENABLE_ADDR = 8'hcb;
   localparam logic [7:0] IVS_IRQ_CLEAR_ADDR = 8'hcc;
   localparam logic [7:0] IVS_MODE_ADDR = 8'hcd;
   localparam logic [7:0] IVS_OPTION_RESET = 8'h00;
   localparam int IVS_LEVEL_BIT = 6;
   localparam int IVS_POLARITY_BIT = 5;
   localparam int IVS_GEN_BIT = 4;
   localparam int IVS_AUX_BIT = 0;
   // ***********************************************
   // Vector addresses
   // ***********************************************
   localparam logic [11:0] IVS_VEC_RESET = 12'hffe;
   localparam logic [11:0] IVS_VEC_NMI = 12'hffc;
   localparam logic [11:0] IVS_VEC_PORT_A = 12'hff6;
   localparam logic [11:0] IVS_VEC_PORT_BC = 12'hff4;
   localparam logic [11:0] IVS_VEC_TIMER = 12'hff2;
   localparam logic [11:0] IVS_VEC_ADC = 12'hff0;
   // Source index: 0 nmi, 1 port A, 2 port BC, 3 timer, 4 adc
   localparam int IVS_NSRC = 5;
   localparam int IVS_SRC_NMI = 0;
   localparam int IVS_SRC_ADC = 4;
   localparam logic [4:0] IVS_STOP_WAKE = 5'h0f;
   typedef enum logic [1:0] {IVS_RUN, IVS_WAIT, IVS_STOP} ivs_mode_e;
endpackage : ivs_pkg

// ==== logic/ivs_edge_latch.sv ====
// Edge or level request latch for one external vector
`timescale 1ns/1ns
module ivs_edge_latch
   import ivs_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic line,
   input wire logic level_mode,
   input wire logic rising,
   input wire logic ack,
   output logic req
);
   logic line_q;
   logic latched;
   wire fall_edge = line_q & ~line;
   wire rise_edge = ~line_q & line;
   wire edge_hit = rising ? rise_edge : fall_edge;
   // Level mode is not stored; request while the line is low
   assign req = level_mode ? ~line : latched;
   // Latch edge; a new edge beats the service clear
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         line_q <= 1'b1;
         latched <= 1'b0;
      end else begin
         line_q <= line;
         latched <= edge_hit | (latched & ~ack);
      end
   end
endmodule : ivs_edge_latch

// ==== logic/ivs_prio_enc.sv ====
// Fixed priority encoder from pending sources to a vector
`timescale 1ns/1ns
module ivs_prio_enc
   import ivs_pkg::*;
(
   input wire logic [IVS_NSRC-1:0] pend,
   output logic any,
   output logic [11:0] vector,
   output logic [IVS_NSRC-1:0] grant
);
   function automatic logic [11:0] vec_of(input int idx);
      case (idx)
         0: vec_of = IVS_VEC_NMI;
         1: vec_of = IVS_VEC_PORT_A;
         2: vec_of = IVS_VEC_PORT_BC;
         3: vec_of = IVS_VEC_TIMER;
         default: vec_of = IVS_VEC_ADC;
      endcase
   endfunction : vec_of
   // Lowest index wins: nmi, then vector 1 down to vector 4
   always_comb begin
      any = 1'b0;
      vector = IVS_VEC_RESET;
      grant = '0;
      for (int i = IVS_NSRC - 1; i >= 0; i--) begin
         if (pend[i]) begin
            any = 1'b1;
            vector = vec_of(i);
            grant = IVS_NSRC'(1) << i;
         end
      end
   end
endmodule : ivs_prio_enc

// ==== verif/ivs_core_model.sv ====
// Processor core model that takes vectors and starts service
`timescale 1ns/1ns
module ivs_core_model (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic irq_req,
   input wire logic [11:0] irq_vector,
   input wire logic hold,
   output logic core_ack,
   output logic [11:0] taken,
   output logic [7:0] n_taken
);
   logic [1:0] gap;
   // Take the offered vector, then rest while the request line settles
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         core_ack <= 1'b0;
         gap <= 2'h0;
         taken <= 12'h000;
         n_taken <= 8'h00;
      end else if (irq_req && !hold && gap == 2'h0 && !core_ack) begin
         core_ack <= 1'b1;
         taken <= irq_vector;
         n_taken <= n_taken + 8'h01;
         gap <= 2'h3;
      end else begin
         core_ack <= 1'b0;
         if (gap != 2'h0) gap <= gap - 2'h1;
      end
   end
endmodule : ivs_core_model

// ==== verif/ivs_top_tb.sv ====
// Testbench for the interrupt vector select block
`timescale 1ns/1ns
module ivs_top_tb
   import ivs_pkg::*;
;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic nmi_line = 1'b1;
   logic port_a_line = 1'b1;
   logic port_bc_line = 1'b1;
   logic timer_zero_flag = 1'b0;
   logic timer_irq_en = 1'b0;
   logic converter_flag = 1'b0;
   logic converter_irq_en = 1'b0;
   logic exec_wait = 1'b0;
   logic exec_stop = 1'b0;
   logic hold = 1'b0;
   logic woke = 1'b0;
   logic core_ack, irq_req, irq, core_wake, low_freq_aux_oscillator;
   logic [7:0] rdata, n_taken, n0;
   logic [11:0] irq_vector, taken;
   logic [1:0] power_mode;
   int n_mismatch = 0;
   int checks = 0;
   always #4 clk = ~clk;
   // Remember any wake pulse
   always @(posedge clk) if (core_wake) woke <= 1'b1;
   ivs_top ivs_top_inst (.clk, .rst_b, .addr, .wdata, .wr, .rd, .rdata, .nmi_line,
      .port_a_line, .port_bc_line, .timer_zero_flag, .timer_irq_en, .converter_flag,
      .converter_irq_en, .core_ack, .exec_wait, .exec_stop, .irq_req, .irq_vector,
      .power_mode, .low_freq_aux_oscillator, .core_wake, .irq);
   ivs_core_model ivs_core_model_inst (.clk, .rst_b, .irq_req, .irq_vector, .hold,
      .core_ack, .taken, .n_taken);
   // ***********************************************
   // Bus and compare helpers
   // ***********************************************
   task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk({4'h0, rdata}, {4'h0, e});
   endtask : rd_chk
   task automatic got(input logic [11:0] v);
      chk(taken, v);
      chk({4'h0, n_taken}, {4'h0, n0 + 8'h01});
   endtask : got
   task automatic mode(input logic [1:0] m);
      chk({10'h0, power_mode}, {10'h0, m});
   endtask : mode
   // Port A edges with the global enable off, then on
   task automatic t_port_a();
      wr_reg(IVS_OPTION_ADDR, 8'h00);
      @(posedge clk) port_a_line <= 1'b0;
      cyc(6);
      chk({11'h0, irq_req}, 12'h000);
      @(posedge clk) port_a_line <= 1'b1;
      wr_reg(IVS_OPTION_ADDR, 8'h10);
      cyc(8);
      n0 = n_taken;
      @(posedge clk) port_a_line <= 1'b0;
      cyc(8);
      got(IVS_VEC_PORT_A);
      @(posedge clk) port_a_line <= 1'b1;
      cyc(8);
      chk({4'h0, n_taken}, {4'h0, n0 + 8'h01});
      wr_reg(IVS_OPTION_ADDR, 8'h50);
      cyc(2);
      n0 = n_taken;
      @(posedge clk) port_a_line <= 1'b0;
      cyc(20);
      chk({11'h0, (n_taken - n0) > 8'h02}, 12'h001);
      @(posedge clk) port_a_line <= 1'b1;
   endtask : t_port_a
   // Vector 2 on each polarity
   task automatic t_port_bc();
      wr_reg(IVS_OPTION_ADDR, 8'h30);
      cyc(8);
      n0 = n_taken;
      @(posedge clk) port_bc_line <= 1'b0;
      cyc(8);
      chk({4'h0, n_taken}, {4'h0, n0});
      @(posedge clk) port_bc_line <= 1'b1;
      cyc(8);
      got(IVS_VEC_PORT_BC);
      wr_reg(IVS_OPTION_ADDR, 8'h10);
      cyc(8);
      n0 = n_taken;
      @(posedge clk) port_bc_line <= 1'b0;
      cyc(8);
      got(IVS_VEC_PORT_BC);
      @(posedge clk) port_bc_line <= 1'b1;
   endtask : t_port_bc
   // Timer and converter pending together while the core stalls
   task automatic t_prio();
      @(posedge clk);
      hold <= 1'b1;
      timer_zero_flag <= 1'b1;
      timer_irq_en <= 1'b1;
      converter_flag <= 1'b1;
      converter_irq_en <= 1'b1;
      cyc(4);
      chk(irq_vector, IVS_VEC_TIMER);
      @(posedge clk) timer_zero_flag <= 1'b0;
      cyc(4);
      chk(irq_vector, IVS_VEC_ADC);
      @(posedge clk) converter_irq_en <= 1'b0;
      cyc(4);
      chk({11'h0, irq_req}, 12'h000);
      @(posedge clk) converter_irq_en <= 1'b1;
      wr_reg(IVS_OPTION_ADDR, 8'h00);
      cyc(4);
      chk({11'h0, irq_req}, 12'h000);
      @(posedge clk) converter_flag <= 1'b0;
      hold <= 1'b0;
   endtask : t_prio
   // Execute the stop instruction and see the block settle in stop
   task automatic enter_stop();
      @(posedge clk) exec_stop <= 1'b1;
      @(posedge clk) exec_stop <= 1'b0;
      cyc(2);
      mode(IVS_STOP);
   endtask : enter_stop
   // Stop mode entry and which sources may end it
   task automatic t_stop();
      enter_stop();
      n0 = n_taken;
      @(posedge clk) nmi_line <= 1'b0;
      cyc(8);
      got(IVS_VEC_NMI);
      mode(IVS_STOP);
      @(posedge clk) nmi_line <= 1'b1;
      wr_reg(IVS_OPTION_ADDR, 8'h10);
      @(posedge clk) converter_flag <= 1'b1;
      cyc(8);
      mode(IVS_STOP);
      @(posedge clk) converter_flag <= 1'b0;
      woke <= 1'b0;
      cyc(8);
      @(posedge clk) port_a_line <= 1'b0;
      cyc(8);
      mode(IVS_RUN);
      chk({11'h0, woke}, 12'h001);
      @(posedge clk) port_a_line <= 1'b1;
      enter_stop();
      @(posedge clk) timer_zero_flag <= 1'b1;
      cyc(4);
      mode(IVS_RUN);
      @(posedge clk) timer_zero_flag <= 1'b0;
      enter_stop();
      @(posedge clk) nmi_line <= 1'b0;
      cyc(4);
      mode(IVS_RUN);
      @(posedge clk) nmi_line <= 1'b1;
      enter_stop();
      @(posedge clk) port_bc_line <= 1'b0;
      cyc(4);
      mode(IVS_RUN);
      @(posedge clk) port_bc_line <= 1'b1;
   endtask : t_stop
   // Clock select, wait mode and the interrupt status path
   task automatic t_regs();
      wr_reg(IVS_CLOCK_ADDR, 8'h01);
      cyc(2);
      chk({11'h0, low_freq_aux_oscillator}, 12'h001);
      @(posedge clk) exec_wait <= 1'b1;
      @(posedge clk) exec_wait <= 1'b0;
      cyc(2);
      mode(IVS_WAIT);
      wr_reg(IVS_IRQ_CLEAR_ADDR, 8'h1f);
      wr_reg(IVS_IRQ_ENABLE_ADDR, 8'h02);
      @(posedge clk) port_a_line <= 1'b0;
      cyc(8);
      mode(IVS_RUN);
      chk({11'h0, irq}, 12'h001);
      rd_chk(IVS_IRQ_STATUS_ADDR, 8'h02);
      wr_reg(IVS_IRQ_ENABLE_ADDR, 8'h00);
      cyc(2);
      chk({11'h0, irq}, 12'h000);
      wr_reg(IVS_IRQ_CLEAR_ADDR, 8'h02);
      wr_reg(IVS_IRQ_ENABLE_ADDR, 8'h02);
      cyc(2);
      chk({11'h0, irq}, 12'h000);
      rd_chk(8'hff, 8'h00);
      @(posedge clk) port_a_line <= 1'b1;
   endtask : t_regs
   task automatic tally_and_finish();
      if (n_mismatch == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : tally_and_finish
   // Main sequence
   initial begin
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      cyc(1);
      chk(irq_vector, IVS_VEC_RESET);
      mode(IVS_RUN);
      chk({11'h0, low_freq_aux_oscillator}, 12'h000);
      rd_chk(IVS_OPTION_ADDR, IVS_OPTION_RESET);
      t_port_a();
      t_port_bc();
      t_prio();
      t_stop();
      t_regs();
      tally_and_finish();
   end
   // Watchdog against a hang
   initial begin
      repeat (5000) @(posedge clk);
      n_mismatch++;
      tally_and_finish();
   end
endmodule : ivs_top_tb
